// ==== inc/tps_defines.svh ====
// Constants for the target port stream interface
// Contract
// - Beat moves when valid and ready high
// - Last flag marks final beat only
// - Header format request keep all ones
// - Raw format keep full except last
// - Keep bit i qualifies byte i
// - Header sideband: source high, destination low
// - Eight-bit IDs zero-pad upper byte
// - Sideband meaningful on first beat only
// - Raw sideband bit 1 carries critical flow
// - User holds header response keep ones
// - User raw response keep full except last
// - User response IDs on first beat
// - User bit 1 requests critical flow
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH
`define TPS_DATA_W 64
`define TPS_KEEP_W 8
`define TPS_USER_W 32
`define TPS_KEEP_FULL 8'hff
`define TPS_SRC_HI 31
`define TPS_SRC_LO 16
`define TPS_DST_HI 15
`define TPS_DST_LO 0
`define TPS_CRF_BIT 1
`endif

// ==== inc/tps_pkg.sv ====
// Types for the target port stream interface
package tps_pkg;
    typedef enum logic {
        TPS_FMT_HEADER = 1'b0,
        TPS_FMT_RAW = 1'b1
    } tps_fmt_t;
    typedef enum logic {
        TPS_ST_FIRST = 1'b0,
        TPS_ST_BODY = 1'b1
    } tps_pos_t;
endpackage

// ==== inc/tps_if.sv ====
// Request and response streams between the device end and the user end
`timescale 1ns/1ps
`include "tps_defines.svh"
interface tps_if;
    logic req_valid;
    logic req_ready;
    logic [`TPS_DATA_W-1:0] req_data;
    logic [`TPS_KEEP_W-1:0] req_keep;
    logic req_last;
    logic [`TPS_USER_W-1:0] req_user;
    logic rsp_valid;
    logic rsp_ready;
    logic [`TPS_DATA_W-1:0] rsp_data;
    logic [`TPS_KEEP_W-1:0] rsp_keep;
    logic rsp_last;
    logic [`TPS_USER_W-1:0] rsp_user;
    modport dev (
        output req_valid, req_data, req_keep, req_last, req_user, rsp_ready,
        input req_ready, rsp_valid, rsp_data, rsp_keep, rsp_last, rsp_user
    );
    modport usr (
        input req_valid, req_data, req_keep, req_last, req_user, rsp_ready,
        output req_ready, rsp_valid, rsp_data, rsp_keep, rsp_last, rsp_user
    );
endinterface

// ==== rtl/tps_dev.sv ====
// Device end: presents inbound requests, accepts user responses
`timescale 1ns/1ps
`include "tps_defines.svh"
module tps_dev (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    tps_if.dev link,
    // Inbound request from the logical layer
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [`TPS_DATA_W-1:0] in_data,
    input wire logic [3:0] in_nbytes,
    input wire logic in_last,
    input wire logic [15:0] in_src_id,
    input wire logic [15:0] in_dst_id,
    input wire logic in_crf,
    input wire logic id_8bit,
    input wire logic fmt_raw,
    // Response handed to the logical layer
    output logic out_valid,
    input wire logic out_ready,
    output logic [`TPS_DATA_W-1:0] out_data,
    output logic [`TPS_KEEP_W-1:0] out_keep,
    output logic out_last,
    output logic [15:0] out_src_id,
    output logic [15:0] out_dst_id,
    output logic out_crf
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Keep mask from byte count, bit i for byte i
    function automatic logic [`TPS_KEEP_W-1:0] keep_of(input logic [3:0] n);
        logic [`TPS_KEEP_W-1:0] k;
        k = '0;
        for (int i = 0; i < `TPS_KEEP_W; i++) begin
            if (4'(i) < n) begin
                k[i] = 1'b1;
            end
        end
        return k;
    endfunction

    // Zero-pad upper byte for 8-bit IDs
    function automatic logic [15:0] pad_id(input logic [15:0] id, input logic short);
        return short ? {8'h00, id[7:0]} : id;
    endfunction

    // ----------------------------------------
    // Request stream
    // ----------------------------------------
    logic req_valid_q;
    logic [`TPS_DATA_W-1:0] req_data_q;
    logic [`TPS_KEEP_W-1:0] req_keep_q;
    logic req_last_q;
    logic [`TPS_USER_W-1:0] req_user_q;
    tps_pkg::tps_pos_t req_pos_q;
    wire req_slot_free = !req_valid_q || link.req_ready;
    wire req_load = in_valid && req_slot_free;
    wire tps_pkg::tps_fmt_t fmt = fmt_raw ? tps_pkg::TPS_FMT_RAW : tps_pkg::TPS_FMT_HEADER;
    wire [`TPS_KEEP_W-1:0] req_keep_d = (fmt == tps_pkg::TPS_FMT_RAW && in_last) ?
        keep_of(in_nbytes) : `TPS_KEEP_FULL;
    wire [`TPS_USER_W-1:0] hdr_user = {pad_id(in_src_id, id_8bit),
        pad_id(in_dst_id, id_8bit)};
    wire [`TPS_USER_W-1:0] raw_user = {30'h0, in_crf, 1'b0};
    wire first_in = (req_pos_q == tps_pkg::TPS_ST_FIRST);
    wire [`TPS_USER_W-1:0] req_user_d = !first_in ? '0 :
        (fmt == tps_pkg::TPS_FMT_RAW ? raw_user : hdr_user);

    assign in_ready = req_slot_free && ce;

    // Output register, held until accepted
    always_ff @(posedge clock) begin
        if (rst) begin
            req_valid_q <= 1'b0;
            req_data_q <= '0;
            req_keep_q <= `TPS_KEEP_FULL;
            req_last_q <= 1'b0;
            req_user_q <= '0;
            req_pos_q <= tps_pkg::TPS_ST_FIRST;
        end else if (ce) begin
            if (req_load) begin
                req_valid_q <= 1'b1;
                req_data_q <= in_data;
                req_keep_q <= req_keep_d;
                req_last_q <= in_last;
                req_user_q <= req_user_d;
                req_pos_q <= in_last ? tps_pkg::TPS_ST_FIRST : tps_pkg::TPS_ST_BODY;
            end else if (link.req_ready) begin
                req_valid_q <= 1'b0;
            end
        end
    end

    assign link.req_valid = req_valid_q;
    assign link.req_data = req_data_q;
    assign link.req_keep = req_keep_q;
    assign link.req_last = req_last_q;
    assign link.req_user = req_user_q;

    // ----------------------------------------
    // Response stream
    // ----------------------------------------
    logic rsp_ready_q;
    tps_pkg::tps_pos_t rsp_pos_q;
    logic [`TPS_USER_W-1:0] rsp_user_first_q;
    wire rsp_take = link.rsp_valid && rsp_ready_q && ce;
    wire rsp_first = (rsp_pos_q == tps_pkg::TPS_ST_FIRST);
    wire [`TPS_USER_W-1:0] rsp_user_eff = rsp_first ? link.rsp_user : rsp_user_first_q;
    wire out_free = !out_valid || out_ready;

    // Ready only when the output slot is sure to be empty at the next edge
    always_ff @(posedge clock) begin
        if (rst) begin
            rsp_ready_q <= 1'b0;
        end else if (ce) begin
            rsp_ready_q <= out_free && !rsp_take;
        end
    end
    assign link.rsp_ready = rsp_ready_q;

    // Capture accepted response beats
    always_ff @(posedge clock) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
            out_keep <= '0;
            out_last <= 1'b0;
            out_src_id <= '0;
            out_dst_id <= '0;
            out_crf <= 1'b0;
            rsp_pos_q <= tps_pkg::TPS_ST_FIRST;
            rsp_user_first_q <= '0;
        end else if (ce) begin
            if (rsp_take) begin
                out_valid <= 1'b1;
                out_data <= link.rsp_data;
                out_keep <= fmt_raw ? link.rsp_keep : `TPS_KEEP_FULL;
                out_last <= link.rsp_last;
                out_src_id <= rsp_user_eff[`TPS_SRC_HI:`TPS_SRC_LO];
                out_dst_id <= rsp_user_eff[`TPS_DST_HI:`TPS_DST_LO];
                out_crf <= fmt_raw & rsp_user_eff[`TPS_CRF_BIT];
                rsp_pos_q <= link.rsp_last ? tps_pkg::TPS_ST_FIRST : tps_pkg::TPS_ST_BODY;
                if (rsp_first) begin
                    rsp_user_first_q <= link.rsp_user;
                end
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// ==== rtl/tps_usr.sv ====
// User end: takes requests, sends responses
`timescale 1ns/1ps
`include "tps_defines.svh"
module tps_usr (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    tps_if.usr link,
    input wire logic fmt_raw,
    input wire logic id_8bit,
    input wire logic crf_enable,
    // Requests delivered to user logic
    output logic rq_valid,
    input wire logic rq_ready,
    output logic [`TPS_DATA_W-1:0] rq_data,
    output logic [`TPS_KEEP_W-1:0] rq_keep,
    output logic rq_last,
    output logic rq_first,
    output logic [`TPS_USER_W-1:0] rq_user,
    // Responses from user logic
    input wire logic rs_valid,
    output logic rs_ready,
    input wire logic [`TPS_DATA_W-1:0] rs_data,
    input wire logic [3:0] rs_nbytes,
    input wire logic rs_last,
    input wire logic [15:0] rs_src_id,
    input wire logic [15:0] rs_dst_id,
    input wire logic rs_crf
);
    // ----------------------------------------
    // Request side
    // ----------------------------------------
    logic first_q;
    logic rq_ready_q;
    wire rq_take = link.req_valid && rq_ready_q && ce;
    wire rq_free = !rq_valid || rq_ready;

    // Ready registered, high only when the slot is empty at the next edge
    always_ff @(posedge clock) begin
        if (rst) begin
            rq_ready_q <= 1'b0;
        end else if (ce) begin
            rq_ready_q <= rq_free && !rq_take;
        end
    end
    assign link.req_ready = rq_ready_q;

    // Capture delivered request beats
    always_ff @(posedge clock) begin
        if (rst) begin
            rq_valid <= 1'b0;
            rq_data <= '0;
            rq_keep <= '0;
            rq_last <= 1'b0;
            rq_first <= 1'b0;
            rq_user <= '0;
            first_q <= 1'b1;
        end else if (ce) begin
            if (rq_take) begin
                rq_valid <= 1'b1;
                rq_data <= link.req_data;
                rq_keep <= link.req_keep;
                rq_last <= link.req_last;
                rq_first <= first_q;
                rq_user <= first_q ? link.req_user : '0;
                first_q <= link.req_last;
            end else if (rq_ready) begin
                rq_valid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Response side
    // ----------------------------------------
    logic v_q;
    logic [`TPS_DATA_W-1:0] d_q;
    logic [`TPS_KEEP_W-1:0] k_q;
    logic l_q;
    logic [`TPS_USER_W-1:0] u_q;
    logic rs_first_q;
    wire slot_free = !v_q || link.rsp_ready;
    wire load = rs_valid && slot_free;
    logic [`TPS_KEEP_W-1:0] km;
    // Keep mask, bit i for byte i
    always_comb begin
        km = '0;
        for (int i = 0; i < `TPS_KEEP_W; i++) begin
            km[i] = (4'(i) < rs_nbytes);
        end
    end
    wire [`TPS_KEEP_W-1:0] k_d = (fmt_raw && rs_last) ? km : `TPS_KEEP_FULL;
    wire [15:0] src_p = id_8bit ? {8'h00, rs_src_id[7:0]} : rs_src_id;
    wire [15:0] dst_p = id_8bit ? {8'h00, rs_dst_id[7:0]} : rs_dst_id;
    wire [`TPS_USER_W-1:0] u_d = !rs_first_q ? '0 :
        (fmt_raw ? {30'h0, rs_crf & crf_enable, 1'b0} : {src_p, dst_p});
    assign rs_ready = slot_free && ce;

    // Response output register
    always_ff @(posedge clock) begin
        if (rst) begin
            v_q <= 1'b0;
            d_q <= '0;
            k_q <= `TPS_KEEP_FULL;
            l_q <= 1'b0;
            u_q <= '0;
            rs_first_q <= 1'b1;
        end else if (ce) begin
            if (load) begin
                v_q <= 1'b1;
                d_q <= rs_data;
                k_q <= k_d;
                l_q <= rs_last;
                u_q <= u_d;
                rs_first_q <= rs_last;
            end else if (link.rsp_ready) begin
                v_q <= 1'b0;
            end
        end
    end
    assign link.rsp_valid = v_q;
    assign link.rsp_data = d_q;
    assign link.rsp_keep = k_q;
    assign link.rsp_last = l_q;
    assign link.rsp_user = u_q;
endmodule

// ==== tb/tps_monitor.sv ====
// Concurrent checks on the two streams between the device and user ends
`timescale 1ns/1ps
module tps_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic fmt_raw,
    input wire logic id_8bit,
    input wire logic crf_enable,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [63:0] req_data,
    input wire logic [7:0] req_keep,
    input wire logic req_last,
    input wire logic [31:0] req_user,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [63:0] rsp_data,
    input wire logic [7:0] rsp_keep,
    input wire logic rsp_last,
    input wire logic [31:0] rsp_user
);
    logic req_first_q;

    // ----------------------------------------
    // First-beat tracking and clocking
    // ----------------------------------------
    // Next request beat opens a packet after a last beat moves
    always_ff @(posedge clock) begin
        if (rst)
            req_first_q <= 1'b1;
        else if (req_valid && req_ready)
            req_first_q <= req_last;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_req_hold_stable: assert property (req_valid && !req_ready |=> req_valid
        && $stable({req_data, req_keep, req_last, req_user})) else $error("request beat moved");
    a_rsp_hold_stable: assert property (rsp_valid && !rsp_ready |=> rsp_valid
        && $stable({rsp_data, rsp_keep, rsp_last, rsp_user})) else $error("response beat moved");
    a_hdr_keep_ones: assert property (req_valid && !fmt_raw |-> req_keep == 8'hff)
        else $error("header keep not full");
    a_raw_keep_body: assert property (req_valid && fmt_raw && !req_last |-> req_keep == 8'hff)
        else $error("raw body keep not full");
    a_tail_keep_low: assert property (req_valid && req_last |-> req_keep != 8'h00
        && ((req_keep + 8'h01) & req_keep) == 8'h00) else $error("tail keep not low bytes");
    a_rsp_keep_ones: assert property (rsp_valid && !fmt_raw |-> rsp_keep == 8'hff)
        else $error("response header keep not full");
    a_id_pad_zero: assert property (req_valid && req_first_q && !fmt_raw && id_8bit
        |-> req_user[31:24] == 8'h00 && req_user[15:8] == 8'h00) else $error("id not padded");
    a_later_user_zero: assert property (req_valid && !req_first_q |-> req_user == 32'h0)
        else $error("later sideband not zero");
    a_rsp_crf_off: assert property (rsp_valid && fmt_raw && !crf_enable |-> !rsp_user[1])
        else $error("critical flow set while disabled");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench joining the device and user ends
`timescale 1ns/1ps
module tb_top;
    logic clock, rst, ce, fmt_raw, id_8bit, crf_enable;
    logic in_valid, in_ready, in_last, in_crf, out_valid, out_ready, out_last, out_crf;
    logic rq_valid, rq_ready, rq_last, rq_first, rs_valid, rs_ready, rs_last, rs_crf;
    logic [63:0] in_data, out_data, rq_data, rs_data;
    logic [3:0] in_nbytes, rs_nbytes;
    logic [15:0] in_src_id, in_dst_id, out_src_id, out_dst_id, rs_src_id, rs_dst_id;
    logic [7:0] out_keep, rq_keep;
    logic [31:0] rq_user;
    logic [127:0] rq_exp[$], rs_exp[$], e;
    int seed, fails, cmp_count, cycles;

    tps_if link_if();
    tps_dev tps_dev_i (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .link(link_if),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .in_nbytes(in_nbytes),
        .in_last(in_last),
        .in_src_id(in_src_id),
        .in_dst_id(in_dst_id),
        .in_crf(in_crf),
        .id_8bit(id_8bit),
        .fmt_raw(fmt_raw),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data),
        .out_keep(out_keep),
        .out_last(out_last),
        .out_src_id(out_src_id),
        .out_dst_id(out_dst_id),
        .out_crf(out_crf)
    );
    tps_usr tps_usr_i (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .link(link_if),
        .fmt_raw(fmt_raw),
        .id_8bit(id_8bit),
        .crf_enable(crf_enable),
        .rq_valid(rq_valid),
        .rq_ready(rq_ready),
        .rq_data(rq_data),
        .rq_keep(rq_keep),
        .rq_last(rq_last),
        .rq_first(rq_first),
        .rq_user(rq_user),
        .rs_valid(rs_valid),
        .rs_ready(rs_ready),
        .rs_data(rs_data),
        .rs_nbytes(rs_nbytes),
        .rs_last(rs_last),
        .rs_src_id(rs_src_id),
        .rs_dst_id(rs_dst_id),
        .rs_crf(rs_crf)
    );
    tps_monitor tps_monitor_i (.clock(clock), .rst(rst), .fmt_raw(fmt_raw), .id_8bit(id_8bit),
        .crf_enable(crf_enable), .req_valid(link_if.req_valid), .req_ready(link_if.req_ready),
        .req_data(link_if.req_data), .req_keep(link_if.req_keep), .req_last(link_if.req_last),
        .req_user(link_if.req_user), .rsp_valid(link_if.rsp_valid),
        .rsp_ready(link_if.rsp_ready), .rsp_data(link_if.rsp_data),
        .rsp_keep(link_if.rsp_keep), .rsp_last(link_if.rsp_last), .rsp_user(link_if.rsp_user));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] kexp(input logic raw, input logic last, input logic [3:0] n);
        kexp = (raw && last) ? 8'hff >> (4'd8 - n) : 8'hff;
    endfunction
    function automatic logic [15:0] idx(input logic [15:0] id);
        idx = id_8bit ? {8'h00, id[7:0]} : id;
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Inbound request packet into the device end, started at a falling edge
    task automatic send_req(input int beats, input logic [3:0] n);
        logic [15:0] s = 16'($random(seed));
        logic [15:0] d = 16'($random(seed));
        logic c = 1'($random(seed));
        for (int b = 0; b < beats; b++) begin
            {in_valid, in_nbytes, in_src_id, in_dst_id, in_crf} = {1'b1, n, s, d, c};
            in_data = {$random(seed), $random(seed)};
            in_last = (b == beats - 1);
            rq_exp.push_back(128'({b == 0, in_data, kexp(fmt_raw, in_last, n), in_last,
                b != 0 ? 32'h0 : fmt_raw ? {30'h0, c, 1'b0} : {idx(s), idx(d)}}));
            while (in_ready !== 1'b1) @(negedge clock);
            @(negedge clock);
        end
    endtask
    // Response packet from user logic into the user end
    task automatic send_rsp(input int beats, input logic [3:0] n);
        logic [15:0] s = 16'($random(seed));
        logic [15:0] d = 16'($random(seed));
        logic c = 1'($random(seed));
        for (int b = 0; b < beats; b++) begin
            {rs_valid, rs_nbytes, rs_src_id, rs_dst_id, rs_crf} = {1'b1, n, s, d, c};
            rs_data = {$random(seed), $random(seed)};
            rs_last = (b == beats - 1);
            rs_exp.push_back(128'({b == 0, rs_data, kexp(fmt_raw, rs_last, n), rs_last,
                (b == 0 && !fmt_raw) ? {idx(s), idx(d)} : 32'h0,
                b == 0 && fmt_raw && c && crf_enable}));
            while (rs_ready !== 1'b1) @(negedge clock);
            @(negedge clock);
        end
    endtask

    // ----------------------------------------
    // Clock, timeout and receivers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            complete_run;
        end
    end
    // Draw a stall pattern, then compare each beat that the next edge moves
    always @(negedge clock) begin
        rq_ready = 1'($random(seed));
        out_ready = 1'($random(seed));
        if (rq_valid === 1'b1 && rq_ready === 1'b1)
            check(128'({rq_first, rq_data, rq_keep, rq_last, (fmt_raw && rq_first)
                ? rq_user & 32'h2 : rq_user}), rq_exp.pop_front());
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            e = rs_exp.pop_front();
            check(128'({e[106], out_data, out_keep, out_last, (e[106] && !fmt_raw)
                ? {out_src_id, out_dst_id} : 32'h0, e[106] && fmt_raw && out_crf}), e);
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {seed, fails, cmp_count, cycles} = {32'h2e13, 32'h0, 32'h0, 32'h0};
        {rst, ce, fmt_raw, id_8bit, crf_enable, in_valid, rs_valid} = 7'b1100000;
        {rq_ready, out_ready, in_last, rs_last, in_crf, rs_crf} = 6'b0;
        {in_data, rs_data, in_nbytes, rs_nbytes} = '0;
        {in_src_id, in_dst_id, rs_src_id, rs_dst_id} = '0;
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        // Every format, id width and critical-flow setting; tail sizes 1 and 8 first
        for (int m = 0; m < 4; m++) begin
            {fmt_raw, id_8bit, crf_enable} = {m[1], m[0], m[1] ^ m[0]};
            fork
                begin
                    for (int p = 0; p < 12; p++)
                        send_req(1 + p % 3, p < 2 ? 4'(1 + 7 * p) : 4'(1 + {$random(seed)} % 8));
                    in_valid = 1'b0;
                end
                begin
                    for (int p = 0; p < 12; p++)
                        send_rsp(1 + p % 3, p < 2 ? 4'(8 - 7 * p) : 4'(1 + {$random(seed)} % 8));
                    rs_valid = 1'b0;
                end
            join
            for (int w = 0; w < 80 && rq_exp.size() + rs_exp.size() != 0; w++)
                @(negedge clock);
            check(128'(rq_exp.size() + rs_exp.size()), 128'h0);
            repeat (4) @(negedge clock);
            $display("Mode %0d done", m);
        end
        complete_run;
    end
endmodule
